// *** include/lbc_pkg.sv ***
package lbc_pkg;
    // Address, data and select widths
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int PCS_N  = 5;
    localparam int MCS_N  = 4;

    // Upper region after reset
    localparam logic [19:0] UCS_RST_LO = 20'hFFC00;
    localparam logic [19:0] UCS_RST_HI = 20'hFFFFF;

    // Numerics error interrupt type
    localparam logic [7:0] NUM_ERR_TYPE = 8'h10;

    // Queue status codes
    localparam logic [1:0] QS_NONE  = 2'h0;
    localparam logic [1:0] QS_FIRST = 2'h1;
    localparam logic [1:0] QS_SUBSQ = 2'h3;
    localparam logic [1:0] QS_EMPTY = 2'h2;

    // Emulation test strap value (both selects low)
    localparam logic [1:0] EMU_STRAP = 2'h0;

    typedef enum logic [1:0] {
        LBC_MEM_RD,
        LBC_MEM_WR,
        LBC_IO_RD,
        LBC_IO_WR
    } lbc_kind_t;
endpackage : lbc_pkg

// *** include/lbc_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface lbc_if;
    import lbc_pkg::*;
    // Bus control
    logic              write_strobe_n;
    logic              ale_qs_lo;
    logic              transceiver_enable_n;
    logic              transceiver_direction;
    logic              ctrl_oe;
    logic              lock_n;
    logic              lock_oe;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_out;
    logic              data_oe;
    logic [DATA_W-1:0] data_in;
    // Ready
    logic              async_ready_in;
    logic              sync_ready_in;
    // Hold
    logic              hold_request;
    logic              hold_acknowledge;
    // Selects and coprocessor lines
    logic              upper_region_select_n;
    logic              lower_region_select_n;
    logic [MCS_N-1:0]  mid_region_select_n;
    logic [PCS_N-1:0]  peripheral_selects_n;
    logic              coproc_transfer_request;
    logic              coproc_error_n;
    logic              coproc_select_n;

    modport dev (
        output write_strobe_n, ale_qs_lo, transceiver_enable_n, transceiver_direction,
        output ctrl_oe, lock_n, lock_oe, addr, data_out, data_oe, hold_acknowledge,
        output upper_region_select_n, lower_region_select_n, mid_region_select_n,
        output peripheral_selects_n, coproc_select_n,
        input  data_in, async_ready_in, sync_ready_in, hold_request,
        input  coproc_transfer_request, coproc_error_n
    );
    modport ext (
        input  write_strobe_n, ale_qs_lo, transceiver_enable_n, transceiver_direction,
        input  ctrl_oe, lock_n, lock_oe, addr, data_out, data_oe, hold_acknowledge,
        input  upper_region_select_n, lower_region_select_n, mid_region_select_n,
        input  peripheral_selects_n, coproc_select_n,
        output data_in, async_ready_in, sync_ready_in, hold_request,
        output coproc_transfer_request, coproc_error_n
    );
endinterface : lbc_if
`default_nettype wire

// *** design/lbc_dev.sv ***
`timescale 1ns/1ps
`default_nettype none
module lbc_dev
    import lbc_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              clk_en,
    // Configuration
    input  wire logic              queue_mode,
    input  wire logic              numerics_mode,
    input  wire logic              mid_enable,
    input  wire logic              ucs_ignore_ready,
    input  wire logic [ADDR_W-1:0] ucs_lo,
    input  wire logic [ADDR_W-1:0] ucs_hi,
    input  wire logic              ucs_prog,
    input  wire logic              lcs_prog,
    input  wire logic [ADDR_W-1:0] lcs_hi,
    input  wire logic [ADDR_W-1:0] mcs_lo,
    input  wire logic [ADDR_W-1:0] mcs_hi,
    input  wire logic [ADDR_W-1:0] pcs_base,
    input  wire logic              pcs_enable,
    input  wire logic [ADDR_W-1:0] coproc_base,
    input  wire logic [1:0]        queue_status,
    input  wire logic              upper_strap,
    input  wire logic              lower_strap,
    // Core request
    input  wire logic              req_valid,
    input  wire lbc_kind_t         req_kind,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    input  wire logic              req_locked,
    input  wire logic              req_boundary,
    input  wire logic              num_start,
    // Core answer
    output logic                   req_ready,
    output logic                   done,
    output logic [DATA_W-1:0]      rdata,
    output logic                   num_irq,
    output logic [7:0]             num_irq_type,
    output logic                   emulation_float_test_mode,
    // Bus
    lbc_if.dev                     bus
);
    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_DATA, S_END, S_HOLD, S_RESUME} lbc_state_t;
    lbc_state_t        state_r;
    lbc_kind_t         kind_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic              ign_r;
    logic [1:0]        async_ready_in_s_r;
    logic [1:0]        hold_s_r;
    logic [1:0]        err_s_r;
    logic              sync_ready_in_r;
    logic              locked_r;
    logic              is_wr;
    logic              is_mem;
    logic              in_ucs;
    logic              in_lcs;
    logic              in_mcs;
    logic [PCS_N-1:0]  in_pcs;
    logic              in_cop;
    logic [1:0]        strap_a_r;
    logic [1:0]        strap_b_r;

    // Input synchronisers
    always_ff @(posedge clk) begin
        if (reset) begin
            async_ready_in_s_r <= 2'h0;
            hold_s_r <= 2'h0;
            err_s_r  <= 2'h3;
        end else if (clk_en) begin
            async_ready_in_s_r <= {async_ready_in_s_r[0], bus.async_ready_in};
            hold_s_r <= {hold_s_r[0], bus.hold_request};
            err_s_r  <= {err_s_r[0], bus.coproc_error_n};
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            sync_ready_in_r <= 1'b0;
        end else if (clk_en) begin
            sync_ready_in_r <= bus.sync_ready_in;
        end
    end

    assign is_wr  = (kind_r == LBC_MEM_WR) || (kind_r == LBC_IO_WR);
    assign is_mem = (kind_r == LBC_MEM_RD) || (kind_r == LBC_MEM_WR);
    assign in_ucs = ucs_prog ? (addr_r >= ucs_lo && addr_r <= ucs_hi)
                             : (is_mem && addr_r >= UCS_RST_LO && addr_r <= UCS_RST_HI);
    assign in_lcs = lcs_prog && is_mem && (addr_r <= lcs_hi);
    assign in_mcs = mid_enable && is_mem && addr_r >= mcs_lo && addr_r <= mcs_hi;
    assign in_cop = numerics_mode && !is_mem && addr_r[ADDR_W-1:4] == coproc_base[ADDR_W-1:4];
    genvar gi;
    generate
        for (gi = 0; gi < PCS_N; gi++) begin : g_pcs
            assign in_pcs[gi] = pcs_enable && addr_r[ADDR_W-1:7] == pcs_base[ADDR_W-1:7]
                                && addr_r[6:4] == 3'(gi);
        end
    endgenerate

    // Bus cycle sequencer
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r  <= S_IDLE;
            kind_r   <= LBC_MEM_RD;
            addr_r   <= '0;
            wdata_r  <= '0;
            ign_r    <= 1'b0;
            locked_r <= 1'b0;
            done     <= 1'b0;
            rdata    <= '0;
        end else if (clk_en) begin
            done <= 1'b0;
            unique case (state_r)
                S_IDLE: begin
                    if (hold_s_r[1] && req_boundary && !locked_r) begin
                        state_r <= S_HOLD;
                    end else if (req_valid) begin
                        kind_r   <= req_kind;
                        addr_r   <= req_addr;
                        wdata_r  <= req_wdata;
                        locked_r <= req_locked;
                        ign_r    <= ucs_ignore_ready;
                        state_r  <= S_ADDR;
                    end else if (req_boundary) begin
                        locked_r <= 1'b0;
                    end
                end
                S_ADDR: state_r <= S_DATA;
                S_DATA: begin
                    if (async_ready_in_s_r[1] || sync_ready_in_r || (ign_r && in_ucs)) begin
                        rdata   <= bus.data_in;
                        done    <= 1'b1;
                        state_r <= S_END;
                    end
                end
                S_END: state_r <= S_IDLE;
                S_HOLD: begin
                    if (!hold_s_r[1]) state_r <= S_RESUME;
                end
                S_RESUME: state_r <= S_IDLE;
            endcase
        end
    end

    // Registered pin drivers
    always_ff @(posedge clk) begin
        if (reset) begin
            bus.write_strobe_n        <= 1'b1;
            bus.ale_qs_lo             <= 1'b0;
            bus.transceiver_enable_n  <= 1'b1;
            bus.transceiver_direction <= 1'b0;
            bus.ctrl_oe               <= 1'b0;
            bus.lock_n                <= 1'b1;
            bus.lock_oe               <= 1'b0;
            bus.addr                  <= '0;
            bus.data_out              <= '0;
            bus.data_oe               <= 1'b0;
            bus.hold_acknowledge      <= 1'b0;
            bus.upper_region_select_n <= 1'b1;
            bus.lower_region_select_n <= 1'b1;
            bus.mid_region_select_n   <= '1;
            bus.peripheral_selects_n  <= '1;
            bus.coproc_select_n       <= 1'b1;
            req_ready                 <= 1'b0;
        end else if (clk_en) begin
            bus.hold_acknowledge <= (state_r == S_HOLD) && hold_s_r[1];
            bus.ctrl_oe          <= (state_r != S_HOLD);
            bus.lock_oe          <= (state_r != S_HOLD);
            bus.lock_n           <= !(locked_r && state_r != S_IDLE && state_r != S_HOLD);
            bus.addr             <= addr_r;
            bus.data_out         <= wdata_r;
            bus.data_oe          <= (state_r == S_DATA) && is_wr;
            if (queue_mode) begin
                bus.write_strobe_n <= queue_status[1];
                bus.ale_qs_lo      <= queue_status[0];
            end else begin
                bus.write_strobe_n <= !((state_r == S_DATA) && is_wr);
                bus.ale_qs_lo      <= (state_r == S_ADDR);
            end
            bus.transceiver_enable_n  <= !(state_r == S_DATA);
            bus.transceiver_direction <= is_wr;
            bus.upper_region_select_n <= !(state_r inside {S_ADDR, S_DATA} && in_ucs);
            bus.lower_region_select_n <= !(state_r inside {S_ADDR, S_DATA} && in_lcs);
            bus.peripheral_selects_n  <= ~(in_pcs & {PCS_N{state_r inside {S_ADDR, S_DATA}}});
            if (numerics_mode) begin
                // Pins 0, 1 and 3 are held high; pin 2 stays the mid-region select
                bus.mid_region_select_n <= {1'b1, !(state_r inside {S_ADDR, S_DATA} && in_mcs),
                                            2'h3};
                bus.coproc_select_n     <= !(state_r inside {S_ADDR, S_DATA} && in_cop);
            end else begin
                bus.mid_region_select_n <= ~{MCS_N{state_r inside {S_ADDR, S_DATA} && in_mcs}};
                bus.coproc_select_n     <= 1'b1;
            end
            req_ready <= (state_r == S_IDLE) && !hold_s_r[1];
        end
    end

    // Numerics error and emulation strap
    always_ff @(posedge clk) begin
        if (reset) begin
            num_irq      <= 1'b0;
            num_irq_type <= 8'h00;
        end else if (clk_en) begin
            num_irq      <= numerics_mode && num_start && !err_s_r[1];
            num_irq_type <= NUM_ERR_TYPE;
        end
    end
    always_ff @(posedge clk) begin
        if (clk_en) begin
            strap_a_r <= {upper_strap, lower_strap};
            strap_b_r <= strap_a_r;
        end
    end
    always_ff @(posedge clk) begin
        if (reset && clk_en) begin
            emulation_float_test_mode <= (strap_b_r == EMU_STRAP);
        end
    end
endmodule : lbc_dev
`default_nettype wire

// *** design/lbc_ext.sv ***
`timescale 1ns/1ps
`default_nettype none
module lbc_ext
    import lbc_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              clk_en,
    // User side
    input  wire logic              want_bus,
    input  wire logic [3:0]        wait_cycles,
    input  wire logic              use_sync_ready,
    input  wire logic [DATA_W-1:0] read_data,
    input  wire logic              coproc_req,
    input  wire logic              coproc_err,
    output logic                   own_bus,
    output logic [DATA_W-1:0]      captured_data,
    output logic                   captured,
    // Bus
    lbc_if.ext                     bus
);
    logic [3:0] wait_r;
    logic       strb_r;

    // Strobe history for the end-of-write edge
    always_ff @(posedge clk) begin
        if (reset) begin
            strb_r <= 1'b1;
        end else if (clk_en) begin
            strb_r <= bus.write_strobe_n;
        end
    end

    // Ready generation after wait states
    always_ff @(posedge clk) begin
        if (reset) begin
            wait_r             <= 4'h0;
            bus.sync_ready_in  <= 1'b0;
            bus.async_ready_in <= 1'b0;
            bus.data_in        <= '0;
        end else if (clk_en) begin
            if (bus.transceiver_enable_n) begin
                wait_r             <= 4'h0;
                bus.sync_ready_in  <= 1'b0;
                bus.async_ready_in <= 1'b0;
            end else begin
                if (wait_r != wait_cycles) wait_r <= wait_r + 4'h1;
                bus.sync_ready_in  <= use_sync_ready && (wait_r == wait_cycles);
                bus.async_ready_in <= !use_sync_ready && (wait_r == wait_cycles);
            end
            bus.data_in <= read_data;
        end
    end

    // Write capture, hold and coprocessor lines
    always_ff @(posedge clk) begin
        if (reset) begin
            captured                    <= 1'b0;
            captured_data               <= '0;
            bus.hold_request            <= 1'b0;
            own_bus                     <= 1'b0;
            bus.coproc_transfer_request <= 1'b0;
            bus.coproc_error_n          <= 1'b1;
        end else if (clk_en) begin
            captured <= 1'b0;
            if (bus.write_strobe_n && !strb_r) begin
                captured      <= 1'b1;
                captured_data <= bus.data_out;
            end
            bus.hold_request            <= want_bus;
            own_bus                     <= bus.hold_acknowledge && want_bus;
            bus.coproc_transfer_request <= coproc_req;
            bus.coproc_error_n          <= !coproc_err;
        end
    end
endmodule : lbc_ext
`default_nettype wire

// *** test/lbc_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module lbc_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Bus control
    input wire logic write_strobe_n,
    input wire logic transceiver_enable_n,
    input wire logic transceiver_direction,
    input wire logic ctrl_oe,
    input wire logic data_oe,
    input wire logic lock_n,
    input wire logic lock_oe,
    input wire logic upper_region_select_n,
    input wire logic lower_region_select_n,
    // Ready and hold
    input wire logic async_ready_in,
    input wire logic sync_ready_in,
    input wire logic hold_request,
    input wire logic hold_acknowledge
);
    default clocking dc @(posedge clk);
    endclocking

    property p_write_dir;
        disable iff (reset) !write_strobe_n && !transceiver_enable_n |-> transceiver_direction;
    endproperty
    a_write_dir: assert property (p_write_dir) else $error("write not transmit");

    property p_den_owner;
        disable iff (reset) !transceiver_enable_n |-> ctrl_oe && !hold_acknowledge;
    endproperty
    a_den_owner: assert property (p_den_owner) else $error("transfer off bus");

    property p_hold_float;
        disable iff (reset) hold_acknowledge |-> !ctrl_oe && !data_oe && !lock_oe;
    endproperty
    a_hold_float: assert property (p_hold_float) else $error("bus driven in hold");

    property p_lock_hold;
        disable iff (reset) $rose(hold_acknowledge) |-> !$past(lock_oe) || $past(lock_n);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("hold during lock");

    property p_hold_req;
        disable iff (reset) $rose(hold_acknowledge) |-> $past(hold_request);
    endproperty
    a_hold_req: assert property (p_hold_req) else $error("unrequested hold");

    property p_hold_drop;
        disable iff (reset) $fell(hold_request) |-> ##[0:8] !hold_acknowledge;
    endproperty
    a_hold_drop: assert property (p_hold_drop) else $error("hold kept");

    property p_ready_wait;
        disable iff (reset) !transceiver_enable_n && upper_region_select_n
            && !sync_ready_in && !$past(sync_ready_in) && !$past(sync_ready_in, 2)
            && !async_ready_in && !$past(async_ready_in) && !$past(async_ready_in, 2)
            && !$past(async_ready_in, 3) |=> !transceiver_enable_n;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("cycle ended early");

    property p_cycle_bound;
        disable iff (reset) $fell(transceiver_enable_n) |-> ##[1:30] transceiver_enable_n;
    endproperty
    a_cycle_bound: assert property (p_cycle_bound) else $error("cycle hung");

    property p_reset_idle;
        reset |=> write_strobe_n && transceiver_enable_n && !hold_acknowledge
            && !lock_oe && lower_region_select_n;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("reset levels");
endmodule : lbc_checker
`default_nettype wire

// *** test/test_local_bus_control_and_selects.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_local_bus_control_and_selects;
    import lbc_pkg::*;
    localparam logic [19:0] LCS_TOP = 20'h03FFF;
    localparam logic [19:0] MCS_LO  = 20'h80000;
    localparam logic [19:0] PCS_AT  = 20'h00400;
    localparam logic [19:0] CP_AT   = 20'h000F0;
    // Bench signals
    logic              clk, reset, clk_en, queue_mode, numerics_mode, mid_enable, ucs_ign;
    logic              lcs_prog, pcs_enable, up_strap, lo_strap, req_valid, req_locked, ucs_prog;
    logic              req_boundary, num_start, req_ready, done, num_irq, emu, want_bus;
    logic              use_sync, coproc_err, own_bus, captured, got;
    logic [1:0]        queue_status;
    logic [3:0]        wait_cycles;
    logic [7:0]        irq_type;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_wdata, rdata, read_data, captured_data, cap, rd;
    logic [11:0]       act;
    lbc_kind_t         req_kind;
    int                err_count, n_compared, lat, n;
    logic [1:0]        qc [4] = '{QS_NONE, QS_FIRST, QS_SUBSQ, QS_EMPTY};

    lbc_if bus ();
    lbc_dev u_lbc_dev (.clk(clk), .reset(reset), .clk_en(clk_en), .queue_mode(queue_mode),
        .numerics_mode(numerics_mode), .mid_enable(mid_enable), .ucs_ignore_ready(ucs_ign),
        .ucs_lo(UCS_RST_LO), .ucs_hi(UCS_RST_HI), .ucs_prog(ucs_prog), .lcs_prog(lcs_prog),
        .lcs_hi(LCS_TOP), .mcs_lo(MCS_LO), .mcs_hi(20'h9FFFF), .pcs_base(PCS_AT),
        .pcs_enable(pcs_enable), .coproc_base(CP_AT), .queue_status(queue_status),
        .upper_strap(up_strap), .lower_strap(lo_strap), .req_valid(req_valid),
        .req_kind(req_kind), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_locked(req_locked), .req_boundary(req_boundary), .num_start(num_start),
        .req_ready(req_ready), .done(done), .rdata(rdata), .num_irq(num_irq),
        .num_irq_type(irq_type), .emulation_float_test_mode(emu), .bus(bus));
    lbc_ext u_lbc_ext (.clk(clk), .reset(reset), .clk_en(clk_en), .want_bus(want_bus),
        .wait_cycles(wait_cycles), .use_sync_ready(use_sync), .read_data(read_data),
        .coproc_req(1'h0), .coproc_err(coproc_err), .own_bus(own_bus),
        .captured_data(captured_data), .captured(captured), .bus(bus));
    lbc_checker u_lbc_checker (.clk(clk), .reset(reset), .write_strobe_n(bus.write_strobe_n),
        .transceiver_enable_n(bus.transceiver_enable_n), .ctrl_oe(bus.ctrl_oe),
        .transceiver_direction(bus.transceiver_direction), .data_oe(bus.data_oe),
        .lock_n(bus.lock_n), .lock_oe(bus.lock_oe), .hold_request(bus.hold_request),
        .upper_region_select_n(bus.upper_region_select_n), .sync_ready_in(bus.sync_ready_in),
        .lower_region_select_n(bus.lower_region_select_n), .async_ready_in(bus.async_ready_in),
        .hold_acknowledge(bus.hold_acknowledge));

    always #5 clk = ~clk;

    // Selects seen active since the last operation began, and the last data stored
    always @(posedge clk) begin
        act <= act | ~{bus.coproc_select_n, bus.upper_region_select_n,
            bus.lower_region_select_n, bus.mid_region_select_n, bus.peripheral_selects_n};
        if (captured)
            cap <= captured_data;
    end

    task automatic end_of_test();
        if (err_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : tick

    task automatic op(input lbc_kind_t k, input logic [19:0] a, input logic [15:0] d,
                      input logic [3:0] w, input logic s);
        int m;
        m = 0;
        act = '0;
        req_kind = k;
        req_addr = a;
        req_wdata = d;
        read_data = d;
        wait_cycles = w;
        use_sync = s;
        req_valid = 1'h1;
        while (req_ready !== 1'h1 && m < 60) begin
            tick(1);
            m++;
        end
        tick(1);
        req_valid = 1'h0;
        lat = 1;
        while (done !== 1'h1 && lat < 60) begin
            tick(1);
            lat++;
        end
        rd = rdata;
        chk(done, 1'h1);
        tick(3);
    endtask : op

    task automatic hold_phase(input logic w);
        n = 0;
        want_bus = w;
        while ((own_bus !== w || bus.hold_acknowledge !== w) && n < 30) begin
            tick(1);
            n++;
        end
        chk(bus.hold_acknowledge, w);
        chk(own_bus, w);
    endtask : hold_phase

    task automatic num_op(input logic e);
        coproc_err = e;
        tick(4);
        num_start = 1'h1;
        tick(1);
        num_start = 1'h0;
        got = 1'h0;
        for (int i = 0; i < 4 && !got; i++) begin
            if (num_irq === 1'h1)
                got = 1'h1;
            else
                tick(1);
        end
        chk(got, e);
        if (e)
            chk(irq_type, NUM_ERR_TYPE);
    endtask : num_op

    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        end_of_test();
    end

    initial begin
        {clk_en, reset, up_strap, lo_strap} = 4'hF;
        {queue_mode, numerics_mode, mid_enable, ucs_ign, lcs_prog, pcs_enable, ucs_prog} = '0;
        {req_valid, req_locked, req_boundary, num_start, want_bus, use_sync, coproc_err} = '0;
        {clk, queue_status, wait_cycles, req_addr, req_wdata, read_data} = '0;
        {err_count, n_compared} = '0;
        req_kind = LBC_MEM_RD;
        tick(3);
        reset = 1'h0;
        chk(emu, 1'h0);
        op(LBC_MEM_WR, UCS_RST_LO, 16'hA55A, 4'h2, 1'h0);
        chk(cap, 16'hA55A);
        chk(act[10:9], 2'h2);
        op(LBC_MEM_RD, UCS_RST_HI, 16'h1234, 4'h1, 1'h1);
        chk(rd, 16'h1234);
        chk(act[10], 1'h1);
        op(LBC_MEM_RD, UCS_RST_LO - 20'h1, 16'h0001, 4'h0, 1'h1);
        chk(act[10], 1'h0);
        ucs_prog = 1'h1;
        op(LBC_IO_RD, UCS_RST_HI, 16'h000A, 4'h0, 1'h0);
        chk(act[10], 1'h1);
        ucs_prog = 1'h0;
        lcs_prog = 1'h1;
        op(LBC_MEM_RD, 20'h00100, 16'h0002, 4'h0, 1'h0);
        chk(act[9], 1'h1);
        op(LBC_IO_RD, 20'h00100, 16'h0003, 4'h0, 1'h0);
        chk(act[9], 1'h0);
        pcs_enable = 1'h1;
        for (int i = 0; i < PCS_N; i++) begin
            op(i[0] ? LBC_MEM_WR : LBC_IO_WR, PCS_AT + 20'(i * 16), 16'h00C0, 4'h1, 1'h1);
            chk(act[4:0], 32'(1 << i));
        end
        mid_enable = 1'h1;
        op(LBC_MEM_RD, MCS_LO + 20'h10, 16'h0004, 4'h0, 1'h0);
        chk(act[8:5] != 4'h0, 1'h1);
        op(LBC_MEM_RD, MCS_LO - 20'h10, 16'h0005, 4'h0, 1'h0);
        chk(act[8:5], 4'h0);
        op(LBC_MEM_RD, UCS_RST_LO, 16'h0006, 4'hF, 1'h0);
        chk(lat >= 15, 1'h1);
        ucs_ign = 1'h1;
        op(LBC_MEM_RD, UCS_RST_LO, 16'h0007, 4'hF, 1'h0);
        chk(lat < 10, 1'h1);
        ucs_ign = 1'h0;
        want_bus = 1'h1;
        tick(20);
        chk(bus.hold_acknowledge, 1'h0);
        req_boundary = 1'h1;
        hold_phase(1'h1);
        chk(req_ready, 1'h0);
        hold_phase(1'h0);
        req_locked = 1'h1;
        fork
            op(LBC_MEM_RD, 20'h00200, 16'h0F0F, 4'h6, 1'h0);
            begin
                tick(3);
                want_bus = 1'h1;
            end
        join
        chk(rd, 16'h0F0F);
        req_locked = 1'h0;
        hold_phase(1'h1);
        hold_phase(1'h0);
        op(LBC_MEM_WR, 20'h00300, 16'h5AA5, 4'h0, 1'h1);
        chk(cap, 16'h5AA5);
        numerics_mode = 1'h1;
        op(LBC_IO_RD, CP_AT, 16'h0008, 4'h0, 1'h0);
        chk(act[11], 1'h1);
        op(LBC_MEM_RD, MCS_LO, 16'h0009, 4'h0, 1'h0);
        chk(act[8:5], 4'h4);
        num_op(1'h1);
        num_op(1'h0);
        queue_mode = 1'h1;
        for (int i = 0; i < 4; i++) begin
            queue_status = qc[i];
            tick(3);
            chk({bus.write_strobe_n, bus.ale_qs_lo}, qc[i]);
        end
        clk_en = 1'h0;
        queue_status = QS_NONE;
        tick(3);
        chk({bus.write_strobe_n, bus.ale_qs_lo}, QS_EMPTY);
        clk_en = 1'h1;
        queue_mode = 1'h0;
        {up_strap, lo_strap, reset} = 3'h1;
        tick(3);
        reset = 1'h0;
        chk(emu, 1'h1);
        end_of_test();
    end
endmodule : test_local_bus_control_and_selects
`default_nettype wire
